/* common/cpa_params.svh */
// Offsets, field positions, reset values and constants for the color palette block.
// Assumes byte addresses on an 8-bit Wishbone address with 32-bit data.
`ifndef CPA_PARAMS_SVH
`define CPA_PARAMS_SVH

`define CPA_OFS_WR_ADDR 8'h00
`define CPA_OFS_HOLD 8'h04
`define CPA_OFS_MASK 8'h08
`define CPA_OFS_RD_ADDR 8'h0C
`define CPA_OFS_PAGE 8'h10
`define CPA_OFS_CTRL 8'h14
`define CPA_OFS_CLKSEL 8'h18
`define CPA_OFS_TEST 8'h1C
`define CPA_OFS_CRC 8'h20

`define CPA_CTRL_DEPTH8 0
`define CPA_CTRL_PLANE_LO 1
`define CPA_CTRL_PLANE_HI 2
`define CPA_CLK_SRC_LO 0
`define CPA_CLK_SRC_HI 2
`define CPA_CLK_DOUBLE 4

`define CPA_RST_MASK 8'hFF
`define CPA_RST_PAGE 8'h00
`define CPA_RST_CTRL 3'h0
`define CPA_RST_CLKSEL 3'h0
`define CPA_RST_CRC 16'hFFFF
`define CPA_CRC_POLY 16'h1021

`define CPA_KEEP_8 8'hFF
`define CPA_KEEP_4 8'h0F
`define CPA_KEEP_2 8'h03
`define CPA_KEEP_1 8'h01

`endif

/* common/cpa_pkg.sv */
// Types shared by the color palette block.
// Assumes cpa_params.svh supplies the numeric constants.
package cpa_pkg;
    typedef enum logic [1:0] {
        CPA_SEQ_RED,
        CPA_SEQ_GREEN,
        CPA_SEQ_BLUE
    } cpa_seq_e;

    typedef enum logic [1:0] {
        CPA_PLANES_8,
        CPA_PLANES_4,
        CPA_PLANES_2,
        CPA_PLANES_1
    } cpa_planes_e;
endpackage

/* design/cpa_palette.sv */
// Color palette: host access over Wishbone, pixel lookup, output mux, checksum.
// Assumes pixel inputs come from logic on clk_i; one clock, synchronous reset.
// What this block does
// - Palette location held in 8-bit pointer, incremented after each RAM transfer.
// - Pointer wraps from the last location back to zero.
// - Every host palette access completes within one clock.
// - Each RAM entry is 24 bits: red, green, blue bytes.
// - Six-bit mode still stores all eight written bits.
// - Six-bit mode readback returns zero in the two top bits.
// - Six-bit mode output shifts low six bits up, zero-fills two low bits.
// - Test data and checksum sample color after the output mux.
// - Write address, then red, green, blue; blue stores the merged word.
// - After storing a triplet the pointer advances for the next entry.
// - Read-address write loads holding register from RAM and increments pointer.
// - Three holding reads return red, green, blue at selected depth.
// - After blue read, holding reloads from pointer and pointer increments.
// - RAM is dual ported; host reads leave video path untouched.
// - With 1, 2 or 4 planes upper address bits come from page bits.
// - Page bits map to same-numbered palette address bits.
// - Pixel address bits are ANDed with the plane mask first.
// - Page bits are merged after masking, never masked.
// - Narrow pixel fields take missing address bits from page bits.
// - After reset the first clock input is the clock source.
// - Dot clock is selected input or its doubled version.
`timescale 1ns/1ps
`include "cpa_params.svh"

module cpa_palette (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] pixel_i,
    input wire logic pixel_valid_i,
    output logic [23:0] color_o,
    output logic color_valid_o,
    output logic [2:0] clk_src_sel_o,
    output logic clk_double_o
);
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] ptr_reg;
    cpa_pkg::cpa_seq_e seq_reg;
    logic [7:0] hold_r_reg;
    logic [7:0] hold_g_reg;
    logic [7:0] hold_b_reg;
    logic [23:0] mem [0:255];
    logic [7:0] mask_reg;
    logic [7:0] page_reg;
    logic [2:0] ctrl_reg;
    logic [4:0] clksel_reg;
    logic [23:0] raw_reg;
    logic raw_valid_reg;
    logic [23:0] color_reg;
    logic color_valid_reg;
    logic [15:0] crc_reg;
    logic take;
    logic wr_take;
    logic rd_take;
    logic depth8;
    logic wr_addr_w;
    logic rd_addr_w;
    logic hold_w;
    logic hold_r;
    logic blue_w;
    logic blue_r;
    logic [7:0] ptr_inc;
    logic [7:0] keep;
    logic [7:0] pix_addr;
    logic [7:0] hold_byte;
    logic [31:0] rd_data;
    logic [23:0] mux_out;

    // Single-cycle answer keeps every access inside one dot clock
    assign take = cyc_i && stb_i && !ack_reg;
    assign wr_take = take && we_i && sel_i[0];
    assign rd_take = take && !we_i;
    assign depth8 = ctrl_reg[`CPA_CTRL_DEPTH8];
    assign wr_addr_w = wr_take && (adr_i == `CPA_OFS_WR_ADDR);
    assign rd_addr_w = wr_take && (adr_i == `CPA_OFS_RD_ADDR);
    assign hold_w = wr_take && (adr_i == `CPA_OFS_HOLD);
    assign hold_r = rd_take && (adr_i == `CPA_OFS_HOLD);
    assign blue_w = hold_w && (seq_reg == cpa_pkg::CPA_SEQ_BLUE);
    assign blue_r = hold_r && (seq_reg == cpa_pkg::CPA_SEQ_BLUE);
    // 8-bit add wraps 255 to 0 by itself
    assign ptr_inc = ptr_reg + 8'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_reg <= 8'h00;
        end else if (wr_addr_w) begin
            ptr_reg <= dat_i[7:0];
        end else if (rd_addr_w) begin
            ptr_reg <= dat_i[7:0] + 8'h01;
        end else if (blue_w || blue_r) begin
            ptr_reg <= ptr_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_reg <= cpa_pkg::CPA_SEQ_RED;
        end else if (wr_addr_w || rd_addr_w) begin
            seq_reg <= cpa_pkg::CPA_SEQ_RED;
        end else if (hold_w || hold_r) begin
            case (seq_reg)
                cpa_pkg::CPA_SEQ_RED: seq_reg <= cpa_pkg::CPA_SEQ_GREEN;
                cpa_pkg::CPA_SEQ_GREEN: seq_reg <= cpa_pkg::CPA_SEQ_BLUE;
                default: seq_reg <= cpa_pkg::CPA_SEQ_RED;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r_reg <= 8'h00;
            hold_g_reg <= 8'h00;
            hold_b_reg <= 8'h00;
        end else if (rd_addr_w) begin
            {hold_r_reg, hold_g_reg, hold_b_reg} <= mem[dat_i[7:0]];
        end else if (blue_r) begin
            {hold_r_reg, hold_g_reg, hold_b_reg} <= mem[ptr_reg];
        end else if (hold_w) begin
            case (seq_reg)
                cpa_pkg::CPA_SEQ_RED: hold_r_reg <= dat_i[7:0];
                cpa_pkg::CPA_SEQ_GREEN: hold_g_reg <= dat_i[7:0];
                default: hold_b_reg <= dat_i[7:0];
            endcase
        end
    end

    // Full eight bits stored whatever the depth
    always_ff @(posedge clk_i) begin
        if (blue_w) begin
            mem[ptr_reg] <= {hold_r_reg, hold_g_reg, dat_i[7:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `CPA_RST_MASK;
            page_reg <= `CPA_RST_PAGE;
            ctrl_reg <= `CPA_RST_CTRL;
            clksel_reg <= {2'b00, `CPA_RST_CLKSEL};
        end else if (wr_take) begin
            case (adr_i)
                `CPA_OFS_MASK: mask_reg <= dat_i[7:0];
                `CPA_OFS_PAGE: page_reg <= dat_i[7:0];
                `CPA_OFS_CTRL: ctrl_reg <= dat_i[2:0];
                `CPA_OFS_CLKSEL: clksel_reg <= {dat_i[`CPA_CLK_DOUBLE],
                    1'b0, dat_i[`CPA_CLK_SRC_HI:`CPA_CLK_SRC_LO]};
                default: ;
            endcase
        end
    end

    // Clock source and doubler request go to the clock generator
    assign clk_src_sel_o = clksel_reg[`CPA_CLK_SRC_HI:`CPA_CLK_SRC_LO];
    assign clk_double_o = clksel_reg[`CPA_CLK_DOUBLE];

    always_comb begin
        case (seq_reg)
            cpa_pkg::CPA_SEQ_RED: hold_byte = hold_r_reg;
            cpa_pkg::CPA_SEQ_GREEN: hold_byte = hold_g_reg;
            default: hold_byte = hold_b_reg;
        endcase
        if (!depth8) begin
            hold_byte = {2'b00, hold_byte[5:0]};
        end
    end

    always_comb begin
        case (adr_i)
            `CPA_OFS_WR_ADDR: rd_data = {24'h000000, ptr_reg};
            `CPA_OFS_RD_ADDR: rd_data = {24'h000000, ptr_reg};
            `CPA_OFS_HOLD: rd_data = {24'h000000, hold_byte};
            `CPA_OFS_MASK: rd_data = {24'h000000, mask_reg};
            `CPA_OFS_PAGE: rd_data = {24'h000000, page_reg};
            `CPA_OFS_CTRL: rd_data = {29'h00000000, ctrl_reg};
            `CPA_OFS_CLKSEL: rd_data = {27'h0000000, clksel_reg};
            `CPA_OFS_TEST: rd_data = {8'h00, color_reg};
            `CPA_OFS_CRC: rd_data = {16'h0000, crc_reg};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h00000000;
        end else if (rd_take) begin
            dat_reg <= rd_data;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Pixel path: mask first, then page bits fill what the planes leave open
    always_comb begin
        case (cpa_pkg::cpa_planes_e'(ctrl_reg[`CPA_CTRL_PLANE_HI:`CPA_CTRL_PLANE_LO]))
            cpa_pkg::CPA_PLANES_4: keep = `CPA_KEEP_4;
            cpa_pkg::CPA_PLANES_2: keep = `CPA_KEEP_2;
            cpa_pkg::CPA_PLANES_1: keep = `CPA_KEEP_1;
            default: keep = `CPA_KEEP_8;
        endcase
    end

    // Same-numbered page bits, untouched by the mask
    assign pix_addr = (pixel_i & mask_reg & keep)
        | (page_reg & ~keep);

    // Separate read port; host traffic never stalls this path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_reg <= 24'h000000;
            raw_valid_reg <= 1'b0;
        end else begin
            raw_reg <= mem[pix_addr];
            raw_valid_reg <= pixel_valid_i;
        end
    end

    always_comb begin
        if (depth8) begin
            mux_out = raw_reg;
        end else begin
            mux_out = {raw_reg[21:16], 2'b00, raw_reg[13:8], 2'b00,
                raw_reg[5:0], 2'b00};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            color_reg <= 24'h000000;
            color_valid_reg <= 1'b0;
        end else begin
            color_reg <= mux_out;
            color_valid_reg <= raw_valid_reg;
        end
    end

    assign color_o = color_reg;
    assign color_valid_o = color_valid_reg;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [23:0] d);
        logic [15:0] c;
        c = crc;
        for (int i = 23; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin
                c = {c[14:0], 1'b0} ^ `CPA_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Checksum sees the muxed color so the whole path is covered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_reg <= `CPA_RST_CRC;
        end else if (wr_take && (adr_i == `CPA_OFS_CRC)) begin
            crc_reg <= `CPA_RST_CRC;
        end else if (color_valid_reg) begin
            crc_reg <= crc_step(crc_reg, color_reg);
        end
    end

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("late palette ack");

    property p_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (blue_w && ptr_reg == 8'hFF) |=> (ptr_reg == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap to zero");

    property p_incr;
        @(posedge clk_i) disable iff (rst_i)
        (blue_w || blue_r) |=> (ptr_reg == $past(ptr_reg) + 8'h01);
    endproperty
    a_incr: assert property (p_incr) else $error("pointer not advanced");

    property p_store;
        @(posedge clk_i) disable iff (rst_i)
        blue_w |=> (mem[$past(ptr_reg)] == {$past(hold_r_reg), $past(hold_g_reg),
            $past(dat_i[7:0])});
    endproperty
    a_store: assert property (p_store) else $error("triplet not stored at pointer");

    property p_rd6;
        @(posedge clk_i) disable iff (rst_i)
        (hold_r && !depth8) |=> (ack_o && dat_o[7:6] == 2'b00);
    endproperty
    a_rd6: assert property (p_rd6) else $error("six-bit readback top bits not zero");

    property p_seq_red;
        @(posedge clk_i) disable iff (rst_i)
        (wr_addr_w || rd_addr_w) |=> (seq_reg == cpa_pkg::CPA_SEQ_RED);
    endproperty
    a_seq_red: assert property (p_seq_red) else $error("sequencer not on red");

    property p_rd_load;
        @(posedge clk_i) disable iff (rst_i)
        rd_addr_w |=> ({hold_r_reg, hold_g_reg, hold_b_reg} == mem[$past(dat_i[7:0])]
            && ptr_reg == $past(dat_i[7:0]) + 8'h01);
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read-address load wrong");

    property p_six_out;
        @(posedge clk_i) disable iff (rst_i)
        (!depth8 && raw_valid_reg) |=> (color_o == {$past(raw_reg[21:16]), 2'b00,
            $past(raw_reg[13:8]), 2'b00, $past(raw_reg[5:0]), 2'b00});
    endproperty
    a_six_out: assert property (p_six_out) else $error("six-bit output shift wrong");

    property p_clk_reset;
        @(posedge clk_i)
        rst_i |=> (clk_src_sel_o == 3'h0 && !clk_double_o);
    endproperty
    a_clk_reset: assert property (p_clk_reset) else $error("bad reset clock");
endmodule

/* verif/cpa_host_model.sv */
// Host processor model: classic Wishbone master issuing single cycles.
// Assumes a slave on clk_i that answers every request with a one-cycle ack.
`timescale 1ns/1ps

module cpa_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // One bus cycle, held until ack; callers may abandon a red, green, blue triplet part way
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released data lines must not keep a stale value
        dat_o <= ~d;
    endtask
endmodule

/* verif/test_color_palette_access.sv */
// Testbench for the color palette: register, palette RAM and pixel path checks.
// Assumes the host model drives Wishbone and the bench drives the pixel port.
`timescale 1ns/1ps
`include "cpa_params.svh"

module test_color_palette_access;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, color_valid_o, clk_double_o;
    logic pixel_valid_i = 1'b0;
    logic [7:0] adr;
    logic [7:0] pixel_i = 8'h00;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [23:0] color_o;
    logic [2:0] clk_src_sel_o;
    logic [7:0] pal [0:8] = '{8'hC5, 8'h3A, 8'h81, 8'h12, 8'h34, 8'h56, 8'hFF, 8'h80, 8'h7F};
    int mismatches = 0;
    int n_tests = 0;

    always #2 clk_i = ~clk_i;

    cpa_palette uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .pixel_i(pixel_i), .pixel_valid_i(pixel_valid_i), .color_o(color_o),
        .color_valid_o(color_valid_o), .clk_src_sel_o(clk_src_sel_o),
        .clk_double_o(clk_double_o));

    cpa_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reference checksum: CRC16 over one 24-bit color, MSB first, from the reset seed
    function automatic logic [31:0] crc_ref(input logic [23:0] d);
        logic [15:0] c;
        c = `CPA_RST_CRC;
        for (int i = 23; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CPA_CRC_POLY : 16'h0000);
        end
        return {16'h0000, c};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
        check(q, e);
    endtask

    // Pixel lookup under a given ctrl, page and mask; color lands two cycles on
    task automatic pix(input logic [2:0] c, input logic [7:0] pg, input logic [7:0] mk,
                       input logic [7:0] px, input logic [23:0] e);
        wr(`CPA_OFS_CTRL, {29'h0000_0000, c});
        wr(`CPA_OFS_PAGE, {24'h00_0000, pg});
        wr(`CPA_OFS_MASK, {24'h00_0000, mk});
        @(posedge clk_i);
        pixel_i <= px;
        pixel_valid_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        check({8'h00, color_o}, {8'h00, e});
        check({31'h0000_0000, color_valid_o}, 32'h0000_0001);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] q;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        check({29'h0000_0000, clk_src_sel_o}, 32'h0000_0000);
        check({31'h0000_0000, clk_double_o}, 32'h0000_0000);
        rd(`CPA_OFS_MASK, 32'h0000_00FF);
        rd(`CPA_OFS_PAGE, 32'h0000_0000);
        rd(`CPA_OFS_CTRL, 32'h0000_0000);
        rd(`CPA_OFS_CLKSEL, 32'h0000_0000);
        rd(`CPA_OFS_CRC, 32'h0000_FFFF);
        rd(8'h24, 32'h0000_0000);
        // Byte lane 0 off: acked, but the mask must keep its value
        host.xfer(1'b1, `CPA_OFS_MASK, 32'h0000_0000, 4'hE, q);
        rd(`CPA_OFS_MASK, 32'h0000_00FF);
        // Three entries from FE so the pointer crosses the top location
        wr(`CPA_OFS_WR_ADDR, 32'h0000_00FE);
        foreach (pal[i]) wr(`CPA_OFS_HOLD, {24'h00_0000, pal[i]});
        rd(`CPA_OFS_WR_ADDR, 32'h0000_0001);
        wr(`CPA_OFS_CTRL, 32'h0000_0001);
        wr(`CPA_OFS_RD_ADDR, 32'h0000_00FE);
        rd(`CPA_OFS_RD_ADDR, 32'h0000_00FF);
        foreach (pal[i]) rd(`CPA_OFS_HOLD, {24'h00_0000, pal[i]});
        rd(`CPA_OFS_WR_ADDR, 32'h0000_0002);
        wr(`CPA_OFS_CTRL, 32'h0000_0000);
        wr(`CPA_OFS_RD_ADDR, 32'h0000_00FE);
        rd(`CPA_OFS_HOLD, 32'h0000_0005);
        rd(`CPA_OFS_HOLD, 32'h0000_003A);
        rd(`CPA_OFS_HOLD, 32'h0000_0001);
        wr(`CPA_OFS_CTRL, 32'h0000_0001);
        wr(`CPA_OFS_RD_ADDR, 32'h0000_00FE);
        rd(`CPA_OFS_HOLD, 32'h0000_00C5);
        // Sequencer sits on green here; a new address must restart at red
        wr(`CPA_OFS_RD_ADDR, 32'h0000_0000);
        rd(`CPA_OFS_HOLD, 32'h0000_00FF);
        wr(`CPA_OFS_WR_ADDR, 32'h0000_0010);
        wr(`CPA_OFS_HOLD, 32'h0000_00AA);
        wr(`CPA_OFS_WR_ADDR, 32'h0000_0010);
        wr(`CPA_OFS_HOLD, 32'h0000_00AB);
        wr(`CPA_OFS_HOLD, 32'h0000_00CD);
        wr(`CPA_OFS_HOLD, 32'h0000_00EF);
        wr(`CPA_OFS_RD_ADDR, 32'h0000_0010);
        rd(`CPA_OFS_HOLD, 32'h0000_00AB);
        rd(`CPA_OFS_HOLD, 32'h0000_00CD);
        rd(`CPA_OFS_HOLD, 32'h0000_00EF);
        pix(3'h1, 8'h00, 8'hFF, 8'hFE, 24'hC53A81);
        pix(3'h3, 8'hF0, 8'hFF, 8'h3E, 24'hC53A81);
        pix(3'h5, 8'hFC, 8'hFF, 8'h03, 24'h123456);
        pix(3'h7, 8'hFE, 8'h00, 8'h01, 24'hC53A81);
        pix(3'h0, 8'h55, 8'h00, 8'hFF, 24'hFC00FC);
        rd(`CPA_OFS_TEST, 32'h00FC_00FC);
        check({8'h00, color_o}, 32'h00FC_00FC);
        // Restart the checksum, then feed it exactly one valid muxed color
        pixel_valid_i <= 1'b0;
        wr(`CPA_OFS_CRC, 32'h0000_0000);
        pixel_valid_i <= 1'b1;
        @(posedge clk_i);
        pixel_valid_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0000_0000, color_valid_o}, 32'h0000_0000);
        rd(`CPA_OFS_CRC, crc_ref(24'hFC00FC));
        wr(`CPA_OFS_CLKSEL, 32'h0000_0012);
        check({29'h0000_0000, clk_src_sel_o}, 32'h0000_0002);
        check({31'h0000_0000, clk_double_o}, 32'h0000_0001);
        rd(`CPA_OFS_CLKSEL, 32'h0000_0012);
        tally_and_finish();
    end
endmodule
